// File: design/timer_pulse_pkg.sv
// Shared constants and types of the six channel timer pulse unit
package timer_pulse_pkg;
    // ==========================================================
    // Sizes
    localparam int CH_N      = 6;
    localparam int CNT_W     = 16;
    localparam int PIN_N     = 16;
    localparam int EXT_N     = 4;
    localparam int IRQ_N     = 26;
    localparam int PRE_W     = 12;
    localparam int DIV_N     = 7;
    localparam int SRC_N     = 12;
    localparam int BUF_FIRST = 2;

    typedef logic [CNT_W-1:0] cnt_t;
    typedef logic [PRE_W-1:0] pre_t;

    localparam cnt_t CNT_MAX  = 16'hffff;
    localparam cnt_t CNT_ZERO = 16'h0000;

    // ==========================================================
    // Access selectors and clear sources
    localparam logic [2:0] SEL_CNT  = 3'h0;
    localparam logic [2:0] SEL_GRA  = 3'h1;
    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [2:0] CLR_A    = 3'h1;
    localparam logic [2:0] CLR_D    = 3'h4;
    localparam logic [2:0] CLR_SYNC = 3'h5;

    // ==========================================================
    // Count sources: 0..6 prescaler taps, 7..10 ext A..D, 11 cascade
    localparam int DIV_LOG [DIV_N] = '{0, 2, 4, 6, 8, 10, 12};
    localparam int SRC_TAB [CH_N][8] = '{
        '{0, 1, 2, 3, 7, 8, 9, 10},
        '{0, 1, 2, 3, 4, 7, 8, 11},
        '{0, 1, 2, 3, 5, 7, 8, 9},
        '{0, 1, 2, 3, 4, 5, 6, 7},
        '{0, 1, 2, 3, 5, 7, 9, 11},
        '{0, 1, 2, 3, 4, 7, 9, 10}};
    localparam int  CASC_SRC [CH_N] = '{0, 2, 0, 0, 5, 0};
    localparam bit  PH_EN    [CH_N] = '{0, 1, 1, 0, 1, 1};
    localparam int  PH_A     [CH_N] = '{0, 0, 2, 0, 2, 0};
    localparam bit  BUF_CH   [CH_N] = '{1, 0, 0, 1, 0, 0};
    localparam int  PIN_BASE [CH_N] = '{0, 4, 6, 8, 12, 14};
    localparam int  PIN_CNT  [CH_N] = '{4, 2, 2, 4, 2, 2};

    typedef enum logic [1:0] {
        ACT_KEEP, ACT_LOW, ACT_HIGH, ACT_TOGGLE
    } match_act_t;

    typedef struct packed {
        logic [2:0]       clk_sel;
        logic [2:0]       clr_src;
        logic             sync;
        logic             pwm;
        logic             phase;
        logic             buf_en;
        logic [3:0]       cap_mode;
        match_act_t [3:0] act;
    } ch_cfg_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] ch;
        logic [2:0] sel;
        cnt_t       data;
    } bus_wr_t;

    typedef struct packed {
        logic [3:0] hit;
        logic       ovf;
        logic       unf;
    } ch_evt_t;
endpackage

// File: design/timer_channel.sv
// One timer channel: counter, general registers, pin logic
`timescale 1ns/1ps
module timer_channel
    import timer_pulse_pkg::*;
#(
    parameter bit HAS_BUF = 1'b0,
    parameter int NREG    = 2
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire ch_cfg_t    cfg,
    input  wire logic       up,
    input  wire logic       dn,
    input  wire logic [3:0] cap,
    input  wire logic       wr_cnt,
    input  wire logic [3:0] wr_gr,
    input  wire cnt_t       wdata,
    input  wire logic       sync_clr,
    output cnt_t            cnt_q,
    output cnt_t [3:0]      gr_q,
    output logic [3:0]      pin_q,
    output logic            clr_req,
    output ch_evt_t         ev
);
    typedef struct packed {
        cnt_t       cnt;
        cnt_t [3:0] gr;
        logic [3:0] pin;
    } ch_st_t;

    ch_st_t     st_q;
    ch_st_t     st_d;
    logic [3:0] act_r;
    logic       buf_mode;
    logic       clr_all;
    logic [1:0] ci;

    // ==========================================================
    // Events and next state
    always_comb begin
        buf_mode = HAS_BUF && cfg.buf_en;
        for (int i = 0; i < 4; i++) begin
            // Buffer registers stop comparing while they buffer
            act_r[i] = (i < NREG) && !(buf_mode && i >= BUF_FIRST); // R8
            ev.hit[i] = act_r[i] && (cfg.cap_mode[i] ? cap[i]
                : ((up | dn) && st_q.cnt == st_q.gr[i]));
        end
        ci = 2'(cfg.clr_src - CLR_A);
        clr_req = cfg.clr_src >= CLR_A && cfg.clr_src <= CLR_D
            && ev.hit[ci]; // R16
        clr_all = clr_req || (sync_clr && cfg.clr_src == CLR_SYNC); // R5
        ev.ovf = up && !clr_all && st_q.cnt == CNT_MAX; // R17
        ev.unf = dn && !clr_all && st_q.cnt == CNT_ZERO; // R17
        st_d = st_q;
        // Software write beats clear and count
        if (wr_cnt) begin
            st_d.cnt = wdata;
        end else if (clr_all) begin
            st_d.cnt = CNT_ZERO; // R16
        end else if (up) begin
            st_d.cnt = cnt_t'(st_q.cnt + 1'b1); // R1
        end else if (dn) begin
            st_d.cnt = cnt_t'(st_q.cnt - 1'b1); // R9
        end
        if (cfg.pwm && clr_all) begin
            st_d.pin = '1; // R7
        end
        for (int i = 0; i < NREG; i++) begin
            if (wr_gr[i]) begin
                st_d.gr[i] = wdata; // R10
            end
            if (ev.hit[i] && cfg.cap_mode[i]) begin
                st_d.gr[i] = st_q.cnt; // R6
                if (buf_mode && i < BUF_FIRST) begin
                    st_d.gr[i + BUF_FIRST] = st_q.gr[i]; // R8
                end
            end else if (ev.hit[i]) begin
                if (buf_mode && i < BUF_FIRST) begin
                    st_d.gr[i] = st_q.gr[i + BUF_FIRST]; // R8
                end
                if (cfg.pwm) begin
                    st_d.pin[i] = 1'b0; // R7
                end else begin
                    case (cfg.act[i]) // R3
                        ACT_LOW:    st_d.pin[i] = 1'b0;
                        ACT_HIGH:   st_d.pin[i] = 1'b1;
                        ACT_TOGGLE: st_d.pin[i] = !st_q.pin[i];
                        default:    st_d.pin[i] = st_q.pin[i];
                    endcase
                end
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cnt_q = st_q.cnt;
    assign gr_q  = st_q.gr;
    assign pin_q = st_q.pin;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    ovf_wrap_a: assert property ( // R1
        ev.ovf && !wr_cnt |=> cnt_q == CNT_ZERO)
        else $error("overflow did not wrap to zero");
    match_clear_a: assert property ( // R16
        clr_req && !wr_cnt |=> cnt_q == CNT_ZERO)
        else $error("match clear did not clear counter");
    toggle_out_a: assert property ( // R3
        ev.hit[0] && !cfg.cap_mode[0] && !cfg.pwm
        && cfg.act[0] == ACT_TOGGLE |=> pin_q[0] != $past(pin_q[0]))
        else $error("toggle output did not toggle");
    buffer_load_a: assert property ( // R8
        buf_mode && ev.hit[0] && !cfg.cap_mode[0] && !wr_gr[0]
        |=> gr_q[0] == $past(gr_q[2]))
        else $error("buffer register not transferred");
endmodule

// File: design/six_channel_timer_pulse_unit.sv
// Top of the six channel timer pulse unit
//
// Notes on behaviour
// R1 - Six channels, each with its own 16-bit up-counter and registers.
// R2 - Each channel selects one of eight count clock sources.
// R3 - Compare match drives the channel pin low, high or toggles it.
// R4 - One counter write updates every counter in the synchronous group.
// R5 - A clear in any synchronous member clears the whole group; the code clears only members whose clear source is CLR_SYNC.
// R6 - Grouped capture and compare events share one counter timing.
// R7 - PWM with synchronous operation gives up to fifteen output phases.
// R8 - Channels 0 and 3 use registers C and D as buffers.
// R9 - Channels 1, 2, 4, 5 may count quadrature phases from ext pins.
// R10 - Every register is reached by one 16-bit access.
// R11 - Match or capture on any channel requests a data transfer.
// R12 - Channels 0 to 3 give pulse pattern generator triggers.
// R13 - Match or capture on register A starts the converter.
// R14 - Module stop halts all counting and register activity.
// R15 - Divide by 1, 4, 16, 64, more on some, plus cascading.
// R16 - A channel clears its counter on its chosen register event.
// R17 - Twenty-six interrupt sources: match, capture, overflow, underflow.
`timescale 1ns/1ps
module six_channel_timer_pulse_unit
    import timer_pulse_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    input  wire logic           mstop,
    input  wire ch_cfg_t [5:0]  cfg,
    input  wire bus_wr_t        bus_wr,
    input  wire logic [2:0]     rd_ch,
    input  wire logic [2:0]     rd_sel,
    output cnt_t                rd_data_q,
    input  wire logic [3:0]     ext_clk_in,
    input  wire logic [15:0]    io_pin_in,
    output logic [15:0]         io_pin_out,
    output logic [15:0]         io_pin_oe_n,
    output logic [25:0]         irq_src_q,
    output logic [5:0]          dtc_req_q,
    output logic [3:0]          ppg_trig_q,
    output logic                adc_trig_q
);
    typedef struct packed {
        pre_t                   pre;
        logic [EXT_N-1:0]       ext_s1;
        logic [EXT_N-1:0]       ext_s2;
        logic [EXT_N-1:0]       ext_s3;
        logic [PIN_N-1:0]       pin_s1;
        logic [PIN_N-1:0]       pin_s2;
        logic [PIN_N-1:0]       pin_s3;
        cnt_t                   rd;
        logic [IRQ_N-1:0]       irq;
        logic [CH_N-1:0]        data_transfer_controller;
        logic [3:0]             pulse_pattern_generator;
        logic                   adc;
    } top_st_t;

    top_st_t              st_q;
    top_st_t              st_d;
    logic                 run;
    logic [DIV_N-1:0]     dt;
    logic [EXT_N-1:0]     ee;
    logic [PIN_N-1:0]     pe;
    logic [SRC_N-1:0]     srcv;
    logic [1:0]           qd;
    logic                 wch_ok;
    logic                 wsync;
    logic                 sync_clr;
    logic [CH_N-1:0]      up;
    logic [CH_N-1:0]      dn;
    logic [CH_N-1:0]      wr_cnt;
    logic [CH_N-1:0]      clr_req;
    logic [CH_N-1:0][3:0] cap;
    logic [CH_N-1:0][3:0] wr_gr;
    logic [CH_N-1:0][3:0] pin_q;
    cnt_t [CH_N-1:0]      cnt_all;
    cnt_t [CH_N-1:0][3:0] gr_all;
    ch_evt_t [CH_N-1:0]   ev;

    // ==========================================================
    // Helpers
    // Prescaler taps: divide by 2^n fires when the low n bits are ones
    function automatic logic [DIV_N-1:0] div_ticks(input pre_t p);
        pre_t m;
        for (int k = 0; k < DIV_N; k++) begin
            m = pre_t'((1 << DIV_LOG[k]) - 1);
            div_ticks[k] = (p & m) == m;
        end
    endfunction

    // Quadrature decode of two synchronised phases, {up, down}
    function automatic logic [1:0] quad(input logic a, input logic a_d,
                                        input logic b, input logic b_d);
        logic ar;
        logic af;
        logic br;
        logic bf;
        ar = a && !a_d;
        af = !a && a_d;
        br = b && !b_d;
        bf = !b && b_d;
        quad[1] = (ar && !b) || (af && b) || (br && a) || (bf && !a);
        quad[0] = (ar && b) || (af && !b) || (br && !a) || (bf && a);
    endfunction

    // ==========================================================
    // Count sources, writes and captures per channel
    always_comb begin
        run  = !mstop; // R14
        dt   = div_ticks(st_q.pre); // R15
        // Edges come from stages two and three, never the first stage
        ee   = st_q.ext_s2 & ~st_q.ext_s3;
        pe   = st_q.pin_s2 & ~st_q.pin_s3;
        wch_ok = bus_wr.ch < 3'(CH_N);
        wsync  = wch_ok && cfg[bus_wr.ch].sync;
        sync_clr = 1'b0;
        srcv = '0;
        qd   = '0;
        for (int c = 0; c < CH_N; c++) begin
            srcv = {PH_EN[c] && ev[CASC_SRC[c]].ovf && c != CASC_SRC[c],
                    ee, dt};
            qd = quad(st_q.ext_s2[PH_A[c]], st_q.ext_s3[PH_A[c]],
                      st_q.ext_s2[PH_A[c] + 1], st_q.ext_s3[PH_A[c] + 1]);
            if (PH_EN[c] && cfg[c].phase) begin
                up[c] = run && qd[1]; // R9
                dn[c] = run && qd[0]; // R9
            end else begin
                up[c] = run && srcv[SRC_TAB[c][cfg[c].clk_sel]]; // R2
                dn[c] = 1'b0;
            end
            wr_cnt[c] = run && bus_wr.wr && bus_wr.sel == SEL_CNT
                && (bus_wr.ch == 3'(c) || (wsync && cfg[c].sync)); // R4
            for (int i = 0; i < 4; i++) begin
                wr_gr[c][i] = run && bus_wr.wr && bus_wr.ch == 3'(c)
                    && bus_wr.sel == 3'(SEL_GRA + i) && i < PIN_CNT[c];
                cap[c][i] = run && i < PIN_CNT[c]
                    && pe[PIN_BASE[c] + i % PIN_CNT[c]];
            end
            sync_clr = sync_clr || (clr_req[c] && cfg[c].sync); // R5
        end
    end

    // ==========================================================
    // Channels; one clock for all keeps grouped events aligned
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        timer_channel #(
            .HAS_BUF (BUF_CH[c]),
            .NREG    (PIN_CNT[c])
        ) u_ch (
            .mclk     (mclk),
            .sys_rst  (sys_rst),
            .cfg      (cfg[c]),
            .up       (up[c]),
            .dn       (dn[c]),
            .cap      (cap[c]),
            .wr_cnt   (wr_cnt[c]),
            .wr_gr    (wr_gr[c]),
            .wdata    (bus_wr.data),
            .sync_clr (sync_clr && cfg[c].sync),
            .cnt_q    (cnt_all[c]),
            .gr_q     (gr_all[c]),
            .pin_q    (pin_q[c]),
            .clr_req  (clr_req[c]),
            .ev       (ev[c])
        );
    end

    // ==========================================================
    // Pin mapping; capture pins float, compare pins drive
    always_comb begin
        io_pin_out  = '0;
        io_pin_oe_n = '1;
        for (int c = 0; c < CH_N; c++) begin
            for (int i = 0; i < PIN_CNT[c]; i++) begin
                io_pin_out[PIN_BASE[c] + i]  = pin_q[c][i]; // R3
                io_pin_oe_n[PIN_BASE[c] + i] = cfg[c].cap_mode[i];
            end
        end
    end

    // ==========================================================
    // Synchronisers, prescaler, read data and triggers
    always_comb begin
        int k;
        k = 0;
        st_d = st_q;
        st_d.ext_s1 = ext_clk_in;
        st_d.ext_s2 = st_q.ext_s1;
        st_d.ext_s3 = st_q.ext_s2;
        st_d.pin_s1 = io_pin_in;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_s3 = st_q.pin_s2;
        if (run) begin
            st_d.pre = pre_t'(st_q.pre + 1'b1); // R14
        end
        // Read answers one cycle later; absent registers read zero
        st_d.rd = CNT_ZERO;
        if (rd_ch < 3'(CH_N) && rd_sel == SEL_CNT) begin
            st_d.rd = cnt_all[rd_ch]; // R10
        end else if (rd_ch < 3'(CH_N) && rd_sel >= SEL_GRA
                     && rd_sel < 3'(SEL_GRA + 4)) begin
            st_d.rd = gr_all[rd_ch][2'(rd_sel - SEL_GRA)]; // R10
        end
        st_d.adc = 1'b0;
        for (int c = 0; c < CH_N; c++) begin
            st_d.data_transfer_controller[c] = |ev[c].hit; // R11
            st_d.adc = st_d.adc || ev[c].hit[0]; // R13
            if (c < 4) begin
                st_d.pulse_pattern_generator[c] = ev[c].hit[0] || ev[c].hit[1]; // R12
            end
            for (int i = 0; i < PIN_CNT[c]; i++) begin
                st_d.irq[k] = ev[c].hit[i]; // R17
                k = k + 1;
            end
            st_d.irq[k] = ev[c].ovf; // R17
            k = k + 1;
            if (PH_EN[c]) begin
                st_d.irq[k] = ev[c].unf; // R17
                k = k + 1;
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_q  = st_q.rd;
    assign irq_src_q  = st_q.irq;
    assign dtc_req_q  = st_q.data_transfer_controller;
    assign ppg_trig_q = st_q.pulse_pattern_generator;
    assign adc_trig_q = st_q.adc;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sync_write_a: assert property ( // R4
        bus_wr.wr && !mstop && bus_wr.sel == SEL_CNT && wsync
        && cfg[3].sync |=> cnt_all[3] == $past(bus_wr.data))
        else $error("group write missed channel three");
    sync_clear_a: assert property ( // R5
        sync_clr && cfg[3].sync && cfg[3].clr_src == CLR_SYNC
        && !wr_cnt[3] |=> cnt_all[3] == CNT_ZERO)
        else $error("group clear missed channel three");
    stop_hold_a: assert property ( // R14
        mstop |=> cnt_all[0] == $past(cnt_all[0]))
        else $error("counter moved in module stop");
    div4_tick_a: assert property ( // R15
        (dt[1] && !mstop) ##1 (!mstop) [*3] |=> dt[1])
        else $error("divide by four tap off period");
    adc_trig_a: assert property ( // R13
        ev[3].hit[0] |=> adc_trig_q ##1 (adc_trig_q == $past(|{
        ev[0].hit[0], ev[1].hit[0], ev[2].hit[0], ev[3].hit[0],
        ev[4].hit[0], ev[5].hit[0]})))
        else $error("converter trigger not raised");
endmodule

// File: test/cpu_bus_model.sv
// Processor-side bus master model for the timer unit
`timescale 1ns/1ps
module cpu_bus_model
    import timer_pulse_pkg::*;
(
    input  wire logic       mclk,
    output bus_wr_t         bus_wr,
    output logic [2:0]      rd_ch,
    output logic [2:0]      rd_sel,
    input  wire cnt_t       rd_data_q
);
    // ==========================================================
    // Idle bus
    initial begin
        bus_wr = '0;
        rd_ch  = 3'h0;
        rd_sel = 3'h0;
    end

    // ==========================================================
    // One whole 16-bit write, strobe up for exactly one edge
    task automatic write_word(input logic [2:0] ch, input logic [2:0] sel,
                              input cnt_t data);
        @(posedge mclk);
        bus_wr <= '{wr: 1'b1, ch: ch, sel: sel, data: data};
        @(posedge mclk);
        // Released fields show the inverse, never a stale copy
        bus_wr <= '{wr: 1'b0, ch: ~ch, sel: ~sel, data: ~data};
    endtask

    // Select held until the edge after the one that samples it
    task automatic read_word(input logic [2:0] ch, input logic [2:0] sel,
                             output cnt_t data);
        @(posedge mclk);
        rd_ch  <= ch;
        rd_sel <= sel;
        repeat (2) @(posedge mclk);
        data = rd_data_q;
        rd_ch  <= ~ch;
        rd_sel <= ~sel;
    endtask
endmodule

// File: test/six_channel_timer_pulse_unit_bench.sv
// Self-checking bench of the six channel timer pulse unit
`timescale 1ns/1ps
module six_channel_timer_pulse_unit_bench;
    import timer_pulse_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic           mclk;
    logic           sys_rst;
    logic           mstop;
    ch_cfg_t [5:0]  cfg;
    bus_wr_t        bus_wr;
    logic [2:0]     rd_ch;
    logic [2:0]     rd_sel;
    cnt_t           rd_data_q;
    logic [3:0]     ext_clk_in;
    logic [15:0]    io_pin_in;
    logic [15:0]    io_pin_out;
    logic [15:0]    io_pin_oe_n;
    logic [25:0]    irq_src_q;
    logic [5:0]     dtc_req_q;
    logic [3:0]     ppg_trig_q;
    logic           adc_trig_q;
    int             n_fail;
    int             tests_run;
    cnt_t           v;
    logic           seen;

    six_channel_timer_pulse_unit u_six_channel_timer_pulse_unit (
        .mclk(mclk), .sys_rst(sys_rst), .mstop(mstop), .cfg(cfg),
        .bus_wr(bus_wr), .rd_ch(rd_ch), .rd_sel(rd_sel),
        .rd_data_q(rd_data_q), .ext_clk_in(ext_clk_in),
        .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
        .io_pin_oe_n(io_pin_oe_n), .irq_src_q(irq_src_q),
        .dtc_req_q(dtc_req_q), .ppg_trig_q(ppg_trig_q),
        .adc_trig_q(adc_trig_q));

    cpu_bus_model u_cpu_bus_model (
        .mclk(mclk), .bus_wr(bus_wr), .rd_ch(rd_ch), .rd_sel(rd_sel),
        .rd_data_q(rd_data_q));

    // 200 MHz
    always #2.5 mclk = ~mclk;

    // ==========================================================
    // Compare and helper tasks
    task automatic check_word(input cnt_t got, input cnt_t exp,
                              input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp,
                              input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %b", $time, what, got);
        end
    endtask

    // Bounded wait for one interrupt source pulse
    task automatic wait_irq(input int idx, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < 40 && !hit; i++) begin
            @(posedge mclk);
            hit = (irq_src_q[idx] === 1'b1);
        end
    endtask

    // Ext pulse long enough to clear the three-flop synchroniser
    task automatic ext_pulse();
        @(posedge mclk);
        ext_clk_in[0] <= 1'b1;
        repeat (4) @(posedge mclk);
        ext_clk_in[0] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_stop();
        check_word(16'(irq_src_q), 16'h0000, "irq after reset");
        check_word(io_pin_out, 16'h0000, "pins after reset");
        u_cpu_bus_model.write_word(3'h1, SEL_GRA, 16'h5555);
        repeat (20) @(posedge mclk);
        u_cpu_bus_model.read_word(3'h1, SEL_GRA, v);
        check_word(v, 16'h0000, "write during stop");
        u_cpu_bus_model.read_word(3'h0, SEL_CNT, v);
        check_word(v, 16'h0000, "count during stop");
        @(posedge mclk);
        mstop <= 1'b0;
        $display("stop test done");
    endtask

    task automatic test_regs();
        u_cpu_bus_model.write_word(3'h1, 3'h3, 16'habcd);
        u_cpu_bus_model.read_word(3'h1, 3'h3, v);
        check_word(v, 16'h0000, "absent reg c on ch1");
        u_cpu_bus_model.write_word(3'h3, 3'h4, 16'h1357);
        u_cpu_bus_model.read_word(3'h3, 3'h4, v);
        check_word(v, 16'h1357, "buffer reg d on ch3");
        $display("register test done");
    endtask

    // Ch2 and ch3 counted by ext A, cleared as a group by ch2 reg A
    task automatic test_sync();
        @(posedge mclk);
        cfg[2].clk_sel <= 3'h5;
        cfg[2].sync    <= 1'b1;
        cfg[2].clr_src <= CLR_A;
        cfg[3].sync    <= 1'b1;
        cfg[3].clr_src <= CLR_SYNC;
        u_cpu_bus_model.write_word(3'h2, SEL_GRA, 16'h0005);
        u_cpu_bus_model.write_word(3'h2, SEL_CNT, 16'h0003);
        u_cpu_bus_model.read_word(3'h3, SEL_CNT, v);
        check_word(v, 16'h0003, "group write");
        repeat (2) ext_pulse();
        u_cpu_bus_model.read_word(3'h3, SEL_CNT, v);
        check_word(v, 16'h0005, "group count");
        ext_pulse();
        u_cpu_bus_model.read_word(3'h3, SEL_CNT, v);
        check_word(v, 16'h0000, "group clear member");
        u_cpu_bus_model.read_word(3'h2, SEL_CNT, v);
        check_word(v, 16'h0000, "group clear owner");
        $display("sync test done");
    endtask

    // Ch1 stands still, so the captured value is known
    task automatic test_capture();
        u_cpu_bus_model.write_word(3'h1, SEL_CNT, 16'h0077);
        @(posedge mclk);
        cfg[1].cap_mode <= 4'h1;
        @(posedge mclk);
        check_flag(io_pin_oe_n[4], 1'b1, "capture pin released");
        io_pin_in[4] <= 1'b1;
        wait_irq(5, seen);
        check_flag(seen, 1'b1, "capture event");
        io_pin_in[4] <= 1'b0;
        u_cpu_bus_model.read_word(3'h1, SEL_GRA, v);
        check_word(v, 16'h0077, "captured count");
        $display("capture test done");
    endtask

    // Ch0 at divide by 1, reg A = 2: event every third cycle
    task automatic test_match();
        logic p1;
        u_cpu_bus_model.write_word(3'h0, SEL_GRA, 16'h0002);
        u_cpu_bus_model.write_word(3'h0, SEL_CNT, 16'h0000);
        @(posedge mclk);
        cfg[0].clr_src <= CLR_A;
        cfg[0].act[0]  <= ACT_TOGGLE;
        cfg[0].clk_sel <= 3'h0;
        wait_irq(0, seen);
        check_flag(seen, 1'b1, "match event");
        check_word(16'(irq_src_q), 16'h0001, "only source 0A");
        check_flag(dtc_req_q[0], 1'b1, "transfer request");
        check_flag(ppg_trig_q[0], 1'b1, "pattern trigger");
        check_flag(adc_trig_q, 1'b1, "converter trigger");
        check_flag(io_pin_oe_n[0], 1'b0, "compare pin driven");
        p1 = io_pin_out[0];
        @(posedge mclk);
        check_flag(irq_src_q[0], 1'b0, "event one cycle");
        repeat (2) @(posedge mclk);
        check_flag(irq_src_q[0], 1'b1, "match period");
        check_flag(io_pin_out[0], ~p1, "pin toggled");
        cfg[0].clk_sel <= 3'h7;
        $display("match test done");
    endtask

    // Ch0 PWM: reg A clear sets pins B to D high, reg B match drops pin B
    task automatic test_pwm();
        u_cpu_bus_model.write_word(3'h0, 3'h2, 16'h0001);
        @(posedge mclk);
        cfg[0].pwm     <= 1'b1;
        cfg[0].clk_sel <= 3'h0;
        wait_irq(0, seen);
        check_flag(io_pin_out[1], 1'b1, "pwm high at clear");
        wait_irq(1, seen);
        check_flag(seen, 1'b1, "pwm match event");
        check_flag(io_pin_out[1], 1'b0, "pwm low at match");
        cfg[0].clk_sel <= 3'h7;
        $display("pwm test done");
    endtask

    // Ch1 quadrature on ext A/B: one full cycle forward, then one back
    task automatic test_phase();
        // Pairs {B, A}: forward 01 11 10 00, then back 10 11 01 00
        logic [15:0] steps;
        steps = 16'h78b4;
        @(posedge mclk);
        cfg[1].phase <= 1'b1;
        for (int s = 7; s >= 0; s--) begin
            @(posedge mclk);
            ext_clk_in[1:0] <= steps[2*s +: 2];
            repeat (3) @(posedge mclk);
            if (s == 4) begin
                u_cpu_bus_model.read_word(3'h1, SEL_CNT, v);
                check_word(v, 16'h007b, "phase count up");
            end
        end
        u_cpu_bus_model.read_word(3'h1, SEL_CNT, v);
        check_word(v, 16'h0077, "phase count down");
        $display("phase test done");
    endtask

    // ==========================================================
    // Main sequence: ext-clocked channels stand still until pulsed
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        mstop = 1'b1;
        ext_clk_in = 4'h0;
        io_pin_in = 16'h0000;
        n_fail = 0;
        tests_run = 0;
        cfg = '0;
        cfg[0].clk_sel = 3'h7;
        cfg[1].clk_sel = 3'h6;
        cfg[2].clk_sel = 3'h6;
        cfg[3].clk_sel = 3'h7;
        cfg[4].clk_sel = 3'h6;
        cfg[5].clk_sel = 3'h7;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        test_stop();
        test_regs();
        test_sync();
        test_capture();
        test_match();
        test_pwm();
        test_phase();
        complete_run();
    end

    // Watchdog, well beyond the roughly 160 cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        complete_run();
    end
endmodule
